// [core/tfc_fan_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module tfc_fan_ctrl
   import tfc_pkg::*;
#(
   parameter bit          AUTO_OFF    = 1'b0,
   parameter int          LOW_TEMP    = DEF_LOW_TEMP,
   parameter int          FULL_TEMP   = DEF_FULL_TEMP,
   parameter int          PERIOD      = PERIOD_CYC,
   parameter int          BLANK       = BLANK_CYC
) (
   input  wire logic              CLK_SYS,
   input  wire logic              SYS_RST,
   input  wire logic [TEMP_W-1:0] JUNCTION_TEMP_CODE,
   input  wire logic              FAN_OFF_REQUEST_N,
   input  wire logic              FAN_PULSE,
   output logic                   FAN_DRIVE,
   output logic                   FAN_FAULT_N,
   output logic                   OVERHEAT_N
);
   // ==========================================================
   // thresholds
   localparam int SPAN = FULL_TEMP - LOW_TEMP;
   localparam int OVER_T = FULL_TEMP + OVER_OFFSET;
   localparam int REL_T  = OVER_T - OVER_HYST;
   initial begin
      if (SPAN < 5 || OVER_T >= (1 << TEMP_W)) $error("bad thresholds");
      if (BLANK < 1 || BLANK >= PERIOD || BLANK > 65535) $error("bad blanking");
   end
   logic [TEMP_W-1:0] thr [0:5];
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_thr
         assign thr[gi] = TEMP_W'(LOW_TEMP + (SPAN * gi) / 5);
      end
   endgenerate
   // ==========================================================
   // input synchronisers
   logic off_req_n;
   logic pulse_s;
   tfc_sync #(.RST_VAL(1'b1)) u_sync_off (
      .CLK_SYS (CLK_SYS),
      .SYS_RST (SYS_RST),
      .din     (FAN_OFF_REQUEST_N),
      .dout    (off_req_n)
   );
   tfc_sync #(.RST_VAL(1'b0)) u_sync_pulse (
      .CLK_SYS (CLK_SYS),
      .SYS_RST (SYS_RST),
      .din     (FAN_PULSE),
      .dout    (pulse_s)
   );
   // ==========================================================
   // band select and overheat alert, live even in shutdown
   logic [BAND_W-1:0] band;
   logic              over_ff;
   logic              nxt_over;
   always_comb begin
      band = BAND_BELOW;
      for (int i = 0; i < 6; i++) begin
         if (JUNCTION_TEMP_CODE >= thr[i]) begin
            band = BAND_W'(i + 1);
         end
      end
      nxt_over = over_ff;
      if (JUNCTION_TEMP_CODE > TEMP_W'(OVER_T)) begin
         nxt_over = 1'b1;
      end else if (JUNCTION_TEMP_CODE <= TEMP_W'(REL_T)) begin
         nxt_over = 1'b0;
      end
   end
   // ==========================================================
   // sequencing state
   tfc_state_t        st_ff;
   tfc_state_t        nxt_st;
   logic [5:0]        per_ff;
   logic [5:0]        nxt_per;
   logic              seen_ff;
   logic              nxt_seen;
   logic              retried_ff;
   logic              nxt_retried;
   logic              latch_ff;
   logic              nxt_latch;
   logic              off_q_ff;
   logic              nxt_off_q;
   logic              pulse_q_ff;
   logic              nxt_pulse_q;
   logic              drv_q_ff;
   logic              nxt_drv_q;
   logic [15:0]       blank_ff;
   logic [15:0]       nxt_blank;
   logic              period_end;
   logic              pwm_on;
   logic [6:0]        duty;
   logic              pulse_ok;
   logic              shut;
   // duty mapping; pwm latches it only at period end
   always_comb begin
      if (over_ff || band == BAND_FULL) begin
         duty = 7'(DUTY_FULL);
      end else if (band == BAND_BELOW) begin
         duty = AUTO_OFF ? 7'h00 : 7'(DUTY_MIN);
      end else begin
         duty = 7'(DUTY_MIN + DUTY_STEP * int'(band));
      end
   end
   tfc_pwm #(.PERIOD(PERIOD)) u_pwm (
      .CLK_SYS    (CLK_SYS),
      .SYS_RST    (SYS_RST),
      .duty_pct   (duty),
      .period_end (period_end),
      .drive_on   (pwm_on)
   );
   assign shut = (st_ff == ST_OFF);
   // blanking counts from each rising edge of the drive
   assign pulse_ok = pulse_s && !pulse_q_ff && (blank_ff == 16'h0000);
   always_comb begin
      nxt_st      = st_ff;
      nxt_per     = per_ff;
      nxt_seen    = seen_ff;
      nxt_retried = retried_ff;
      nxt_latch   = latch_ff;
      nxt_off_q   = off_req_n;
      nxt_pulse_q = pulse_s;
      nxt_drv_q   = FAN_DRIVE;
      nxt_blank   = (blank_ff != 16'h0000) ? blank_ff - 16'h0001 : blank_ff;
      if (FAN_DRIVE && !drv_q_ff) begin
         nxt_blank = 16'(BLANK);
      end
      if (pulse_ok) begin
         nxt_seen = 1'b1;
      end
      // auto-off with the fan stopped holds ST_START with the count cleared, no fault watch
      if (AUTO_OFF && duty == 7'h00 && st_ff != ST_OFF) begin
         nxt_st   = ST_START;
         nxt_per  = 6'h00;
         nxt_seen = 1'b0;
      end else begin
         case (st_ff)
            ST_START, ST_RETRY: begin
               if (period_end) begin
                  nxt_per = per_ff + 6'h01;
                  if (per_ff == 6'(STARTUP_PERIODS - 1)) begin
                     nxt_per  = 6'h00;
                     nxt_seen = 1'b0;
                     nxt_st   = seen_ff || pulse_ok ? ST_RUN :
                                (st_ff == ST_RETRY ? ST_OFF : ST_RUN);
                     if (st_ff == ST_RETRY && !(seen_ff || pulse_ok)) begin
                        nxt_latch = 1'b1;
                     end
                  end
               end
            end
            ST_RUN: begin
               if (pulse_ok) begin
                  nxt_per  = 6'h00;
               end else if (period_end) begin
                  nxt_per = per_ff + 6'h01;
                  if (per_ff == 6'(MISS_PERIODS - 1)) begin
                     nxt_per  = 6'h00;
                     nxt_seen = 1'b0;
                     if (retried_ff) begin
                        nxt_st    = ST_OFF;
                        nxt_latch = 1'b1;
                     end else begin
                        nxt_st      = ST_RETRY;
                        nxt_retried = 1'b1;
                     end
                  end
               end
            end
            ST_OFF: begin
               nxt_per = 6'h00;
            end
            default: begin
               nxt_st = ST_OFF;
            end
         endcase
      end
      if (!off_req_n) begin
         nxt_st = ST_OFF;
         nxt_per = 6'h00;
         // pin shutdown never raises a new fault, fault output must stay high
         nxt_latch = latch_ff;
      end else if (off_q_ff == 1'b0) begin
         // release clears the fault latch and restarts the fan
         nxt_st      = ST_START;
         nxt_latch   = 1'b0;
         nxt_retried = 1'b0;
         nxt_per     = 6'h00;
         nxt_seen    = 1'b0;
      end
   end
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         st_ff      <= ST_START;
         per_ff     <= 6'h00;
         seen_ff    <= 1'b0;
         retried_ff <= 1'b0;
         latch_ff   <= 1'b0;
         off_q_ff   <= 1'b1;
         pulse_q_ff <= 1'b0;
         drv_q_ff   <= 1'b0;
         blank_ff   <= 16'h0000;
         over_ff    <= 1'b0;
      end else begin
         st_ff      <= nxt_st;
         per_ff     <= nxt_per;
         seen_ff    <= nxt_seen;
         retried_ff <= nxt_retried;
         latch_ff   <= nxt_latch;
         off_q_ff   <= nxt_off_q;
         pulse_q_ff <= nxt_pulse_q;
         drv_q_ff   <= nxt_drv_q;
         blank_ff   <= nxt_blank;
         over_ff    <= nxt_over;
      end
   end
   // ==========================================================
   // outputs; start-up forces full drive unless auto-off has stopped the fan
   always_comb begin
      FAN_DRIVE = 1'b0;
      if (st_ff == ST_START || st_ff == ST_RETRY) begin
         FAN_DRIVE = !(AUTO_OFF && duty == 7'h00);
      end else if (st_ff == ST_RUN) begin
         FAN_DRIVE = pwm_on && !(AUTO_OFF && duty == 7'h00);
      end
   end
   assign FAN_FAULT_N = !(latch_ff && off_req_n);
   assign OVERHEAT_N  = !over_ff;
   // ==========================================================
   // checks
   a_off_drive_low: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      shut |-> !FAN_DRIVE)
      else $error("drive high in shutdown");
   a_fault_high_off: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      !off_req_n |-> FAN_FAULT_N)
      else $error("fault low during shutdown");
   a_over_trip: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      JUNCTION_TEMP_CODE > TEMP_W'(OVER_T) |=> !OVERHEAT_N)
      else $error("overheat alert missed");
   a_over_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      !OVERHEAT_N && JUNCTION_TEMP_CODE > TEMP_W'(REL_T) |=> !OVERHEAT_N)
      else $error("overheat released early");
   a_over_full: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      over_ff |-> duty == 7'(DUTY_FULL))
      else $error("duty not full in overheat");
   a_below_off: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      AUTO_OFF && JUNCTION_TEMP_CODE < thr[0] && !over_ff |-> !FAN_DRIVE)
      else $error("auto-off drive high");
   a_release_start: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      $rose(off_req_n) |=> st_ff == ST_START)
      else $error("no restart on release");
   a_start_high: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      st_ff == ST_START && duty != 7'h00 |-> FAN_DRIVE)
      else $error("start-up drive low");
   a_latch_off: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      $rose(latch_ff) |-> st_ff == ST_OFF && !FAN_FAULT_N)
      else $error("fault latch without shutdown");
   // ==========================================================
   // fault sequencing, band mapping and overheat release; latch only leaves on a pin toggle
   a_band_full: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      band == BAND_FULL |-> duty == 7'(DUTY_FULL))
      else $error("full band duty not full");
   a_retry_drive: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      st_ff == ST_RETRY && duty != 7'h00 |-> FAN_DRIVE)
      else $error("retry drive low");
   a_retry_once: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      st_ff == ST_RETRY |-> retried_ff)
      else $error("retry without flag");
   a_miss_count: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      st_ff == ST_RUN |-> per_ff < 6'(MISS_PERIODS))
      else $error("missing pulse count overrun");
   a_latch_stays: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      latch_ff && off_req_n && off_q_ff |=> latch_ff && shut)
      else $error("fault latch dropped");
   a_fault_in_off: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      !FAN_FAULT_N |-> shut && !FAN_DRIVE)
      else $error("fault low while running");
   a_over_release: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      !OVERHEAT_N && JUNCTION_TEMP_CODE <= TEMP_W'(REL_T) |=> OVERHEAT_N)
      else $error("overheat not released");
endmodule // tfc_fan_ctrl
`default_nettype wire

// [core/tfc_pwm.sv]
`timescale 1ns/1ps
`default_nettype none
module tfc_pwm
   import tfc_pkg::*;
#(
   parameter int PERIOD = PERIOD_CYC
) (
   input  wire logic       CLK_SYS,
   input  wire logic       SYS_RST,
   input  wire logic [6:0] duty_pct,
   output logic            period_end,
   output logic            drive_on
);
   // ==========================================================
   // period counter; duty is latched at the boundary only
   localparam int CW = $clog2(PERIOD + 1);
   initial begin
      if (PERIOD < 100) $error("period too short");
   end
   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;
   logic [6:0]    duty_ff;
   logic [6:0]    nxt_duty;
   logic [CW-1:0] high_cyc;
   logic          out_ff;
   logic          nxt_out;
   always_comb begin
      period_end = (cnt_ff == CW'(PERIOD - 1));
      nxt_cnt    = period_end ? '0 : cnt_ff + 1'b1;
      nxt_duty   = period_end ? duty_pct : duty_ff;
      high_cyc   = CW'((longint'(PERIOD) * duty_ff) / 100);
      nxt_out    = (nxt_cnt < high_cyc) || (duty_ff >= 7'(DUTY_FULL));
      if (period_end) begin
         nxt_out = 1'b0;
      end
   end
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         cnt_ff  <= '0;
         duty_ff <= 7'h64;
         out_ff  <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         duty_ff <= nxt_duty;
         out_ff  <= nxt_out;
      end
   end
   assign drive_on = out_ff || (duty_ff >= 7'(DUTY_FULL) && !period_end);
   a_duty_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
      !$past(period_end) |-> duty_ff == $past(duty_ff))
      else $error("duty changed mid period");
endmodule // tfc_pwm
`default_nettype wire

// [core/tfc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module tfc_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic CLK_SYS,
   input  wire logic SYS_RST,
   input  wire logic din,
   output logic      dout
);
   // ==========================================================
   // two-stage synchroniser; stage one feeds stage two only
   logic meta_ff;
   logic sync_ff;
   logic nxt_meta;
   logic nxt_sync;
   always_comb begin
      nxt_meta = din;
      nxt_sync = meta_ff;
   end
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end
   assign dout = sync_ff;
endmodule // tfc_sync
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
   import tfc_pkg::*;
   // short period keeps the 32-period timers inside the run
   localparam int P = 500;
   localparam int B = 10;

   typedef struct packed {
      logic [7:0] t;
      logic [6:0] pct;
      logic       hot_n;
   } tfc_row_t;

   logic              clk        = 1'b0;
   logic              rst        = 1'b1;
   logic [TEMP_W-1:0] temp       = 8'h1e;
   logic              off_n      = 1'b1;
   logic              stall      = 1'b0;
   logic [15:0]       gap        = 16'h0025;
   wire logic         pulse;
   wire logic         drive;
   wire logic         fault_n;
   wire logic         hot_n;
   wire logic         drive2;
   int                num_errors  = 0;
   int                comparisons = 0;
   tfc_row_t          rows [12] = '{
      '{8'h14, 7'h28, 1'b1}, '{8'h19, 7'h32, 1'b1}, '{8'h1c, 7'h32, 1'b1},
      '{8'h1d, 7'h3c, 1'b1}, '{8'h24, 7'h46, 1'b1}, '{8'h25, 7'h50, 1'b1},
      '{8'h2c, 7'h5a, 1'b1}, '{8'h2d, 7'h64, 1'b1}, '{8'h37, 7'h64, 1'b1},
      '{8'h38, 7'h64, 1'b0}, '{8'h33, 7'h64, 1'b0}, '{8'h32, 7'h64, 1'b1}};

   tfc_fan_ctrl #(.PERIOD(P), .BLANK(B)) i_dut (
      .CLK_SYS(clk), .SYS_RST(rst), .JUNCTION_TEMP_CODE(temp),
      .FAN_OFF_REQUEST_N(off_n), .FAN_PULSE(pulse), .FAN_DRIVE(drive),
      .FAN_FAULT_N(fault_n), .OVERHEAT_N(hot_n));
   tfc_fan_ctrl #(.AUTO_OFF(1'b1), .PERIOD(P), .BLANK(B)) i_dut_auto (
      .CLK_SYS(clk), .SYS_RST(rst), .JUNCTION_TEMP_CODE(temp),
      .FAN_OFF_REQUEST_N(off_n), .FAN_PULSE(pulse), .FAN_DRIVE(drive2),
      .FAN_FAULT_N(), .OVERHEAT_N());
   tfc_fan_model i_fan (
      .clk(clk), .drive(drive), .stall(stall), .gap(gap), .pulse(pulse));

   always #2.5 clk = ~clk;

   // ==========================================================
   // helpers
   task automatic chk(input logic ok, input string what);
      comparisons++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("MISMATCH at %0t: %s", $time, what);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // high cycles over one period do not depend on where the count starts
   task automatic measure(output int h1, output int h2);
      h1 = 0;
      h2 = 0;
      repeat (P) begin
         @(negedge clk);
         h1 += int'(drive === 1'b1);
         h2 += int'(drive2 === 1'b1);
      end
   endtask

   task automatic hold_high(input int n, input string what);
      int lo;
      lo = 0;
      repeat (n) begin
         @(negedge clk);
         if (drive !== 1'b1) lo++;
      end
      chk(lo == 0, what);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ==========================================================
   // tests
   initial begin
      int h1, h2, n;
      cyc(3);
      chk(drive === 1'b1 && fault_n === 1'b1 && hot_n === 1'b1, "reset");
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      $display("test reset done");
      hold_high(31 * P, "start-up drive high");
      cyc(2 * P);
      @(posedge clk);
      gap <= 16'h0096;
      for (int i = 0; i < 12; i++) begin
         @(posedge clk);
         temp <= rows[i].t;
         cyc(2 * P);
         measure(h1, h2);
         n = P * int'(rows[i].pct) / 100;
         chk(h1 >= n - 2 && h1 <= n + 2, "duty step");
         chk(hot_n === rows[i].hot_n, "overheat alert");
         if (rows[i].t < 8'h19) chk(h2 == 0, "auto-off drive");
      end
      $display("test duty table done");
      @(posedge clk);
      temp <= 8'h3c;
      off_n <= 1'b0;
      cyc(5);
      measure(h1, h2);
      chk(h1 == 0 && fault_n === 1'b1, "shutdown levels");
      chk(hot_n === 1'b0, "overheat in shutdown");
      @(posedge clk);
      temp <= 8'h1e;
      off_n <= 1'b1;
      gap <= 16'h0025;
      cyc(5);
      hold_high(30 * P, "restart drive high");
      cyc(2 * P);
      $display("test shutdown done");
      @(posedge clk);
      stall <= 1'b1;
      n = 0;
      while (fault_n !== 1'b0 && n < 70 * P) begin
         @(negedge clk);
         n++;
      end
      chk(n >= 62 * P && n <= 66 * P, "fault timing");
      measure(h1, h2);
      chk(h1 == 0 && fault_n === 1'b0, "fault latched");
      @(posedge clk);
      off_n <= 1'b0;
      stall <= 1'b0;
      cyc(5);
      chk(fault_n === 1'b1 && drive === 1'b0, "fault cleared");
      @(posedge clk);
      off_n <= 1'b1;
      cyc(5);
      chk(drive === 1'b1 && fault_n === 1'b1, "fan restarted");
      $display("test fault done");
      final_report();
   end

   // about 84k cycles expected, limit set with some margin
   initial begin
      repeat (95000) @(posedge clk);
      num_errors++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      final_report();
   end
endmodule // tb
`default_nettype wire

// [dv/tfc_fan_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// fan and sense network model
module tfc_fan_model (
   input  wire logic        clk,
   input  wire logic        drive,
   input  wire logic        stall,
   input  wire logic [15:0] gap,
   output logic             pulse
);
   logic        drive_d = 1'b0;
   logic [15:0] cnt     = 16'h0000;
   logic [1:0]  hold    = 2'h0;

   // a switch-on spike reaches the sense input even from a stalled rotor,
   // so a detector that does not blank it never sees the stall
   always @(posedge clk) begin
      drive_d <= drive;
      if (drive && !drive_d) begin
         hold <= 2'h2;
      end else if (drive && !stall && cnt == gap) begin
         hold <= 2'h2;
      end else if (hold != 2'h0) begin
         hold <= hold - 2'h1;
      end
      cnt <= (!drive || cnt == gap) ? 16'h0000 : cnt + 16'h0001;
   end

   // commutation only chops current while the drive is on
   assign pulse = (hold != 2'h0);
endmodule // tfc_fan_model
`default_nettype wire

// [include/tfc_pkg.sv]
`default_nettype none
package tfc_pkg;
   // ==========================================================
   // clock and timing
   localparam longint CLK_HZ          = 64'd200000000;
   localparam int     PWM_HZ          = 15;
   // nominal 15 Hz period at 200 MHz
   localparam int     PERIOD_CYC      = int'(CLK_HZ / PWM_HZ);
   localparam int     STARTUP_PERIODS = 32;
   localparam int     MISS_PERIODS    = 32;
   // blanking after drive turns on, in microseconds
   localparam int     BLANK_US        = 100;
   localparam int     BLANK_CYC       = int'((BLANK_US * CLK_HZ) / 1000000);
   // ==========================================================
   // duty steps in percent
   localparam int     DUTY_MIN        = 40;
   localparam int     DUTY_STEP       = 10;
   localparam int     DUTY_FULL       = 100;
   // ==========================================================
   // temperature
   localparam int     TEMP_W          = 8;
   localparam int     OVER_OFFSET     = 10;
   localparam int     OVER_HYST       = 5;
   localparam int     DEF_LOW_TEMP    = 25;
   localparam int     DEF_FULL_TEMP   = 45;
   localparam int     BAND_W          = 3;
   localparam logic [2:0] BAND_BELOW  = 3'h0;
   localparam logic [2:0] BAND_FULL   = 3'h6;
   // ==========================================================
   // sequencing states
   typedef enum logic [3:0] {
      ST_START = 4'h1,
      ST_RUN   = 4'h2,
      ST_RETRY = 4'h4,
      ST_OFF   = 4'h8
   } tfc_state_t;
endpackage
`default_nettype wire
